// ===== common/osdg_defs.vh
// Purpose: Shared constants for the overlay region descriptor block
// Assumes: Descriptor words are 32 bits, read one word per acknowledge
// Notes: Field positions give the least significant bit of each field
// Operation
// - Gain after filter, only when enabled
// - Six-bit gain acts as value over 32
// - Alpha and one-minus-alpha never gain scaled
// - Add ten-bit offset after gain multiply
// - Enable low bypasses both gain and offset
// - Mix mode: pixel, global, proportional, none
// - Filter mode: none, flicker, flutter; 11 reserved
// - Stop bit ends overlay after current region
// - New palette bit loads palette first
// - First color goes to load index entry
// - Eight-bit count sets colors to load
// - Count zero still loads one color
// - Global mode uses weight, clamped to 80h
// - Proportional mode scales alpha by mix gain
// - Top bit multiplies, else divides by gain/128
// - 22-bit total pixels per field
// - 12-bit pixel count on every line
// - Advance field pointer by pitch each line inside the region rows
// - 11-bit top and bottom line bounds
// - 12-bit left and right pixel bounds
// - Separate top and bottom field pointers
// - Next descriptor fetched from next pointer
`ifndef OSDG_DEFS_VH
`define OSDG_DEFS_VH

// Descriptor geometry
`define OSDG_HDR_WORDS 4'hA
`define OSDG_WORD_STEP 32'h0000_0004

// Word 0 fields
`define OSDG_W0_STOP 31
`define OSDG_W0_NEWPAL 30
`define OSDG_W0_FILT 28
`define OSDG_W0_MIX 26
`define OSDG_W0_GAIN_ENABLE 25
`define OSDG_W0_GAIN 19
`define OSDG_W0_OFFS 0
// Word 1 fields
`define OSDG_W1_LDIDX 24
`define OSDG_W1_LDCNT 16
`define OSDG_W1_PITCH 0
// Word 2 and 3 fields
`define OSDG_W2_TOTAL 0
`define OSDG_W3_LINEPIX 0
// Word 4 and 5 fields
`define OSDG_W4_WEIGHT 24
`define OSDG_W4_YBOT 12
`define OSDG_W4_XLEFT 0
`define OSDG_W5_MIXGAIN 23
`define OSDG_W5_YTOP 12
`define OSDG_W5_XRIGHT 0
// Pointer word indices
`define OSDG_IDX_BOTP 6
`define OSDG_IDX_TOPP 7
`define OSDG_IDX_PALP 8
`define OSDG_IDX_NEXTP 9

// Encodings
`define OSDG_MIX_PIXEL 2'h0
`define OSDG_MIX_GLOBAL 2'h1
`define OSDG_MIX_PROP 2'h2
`define OSDG_MIX_NONE 2'h3
`define OSDG_FILT_FLICKER 2'h1
`define OSDG_FILT_FLUTTER 2'h2
`define OSDG_ALPHA_FULL 8'h80
`define OSDG_COLOR_MAX 10'h3FF
`define OSDG_GAIN_SHIFT 5

// Buffer shape
`define OSDG_FIFO_WIDTH 38
`define OSDG_FIFO_DEPTH 8
`define OSDG_FIFO_AW 3

`endif

// ===== verilog/osdg_region.v
// Purpose: Overlay region descriptor fetch, palette load and gain stage
// Assumes: Memory answers each read with mem_ack_in and data together
// Notes: Colour output passes an 8-word buffer toward the mixer
`timescale 1ns/1ps
`include "osdg_defs.vh"

module osdg_fifo #(
    parameter WIDTH = `OSDG_FIFO_WIDTH,
    parameter DEPTH = `OSDG_FIFO_DEPTH,
    parameter AW = `OSDG_FIFO_AW
)(
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Fill side
    input wire in_valid_in,
    input wire [WIDTH-1:0] in_data_in,
    output reg in_ready_out,
    // Drain side
    output reg out_valid_out,
    output wire [WIDTH-1:0] out_data_out,
    input wire out_ready_in
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;
    wire [AW:0] count_d;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data_out = mem[rd_ptr_q];

    // Storage has no reset; only pointers, count and flags need one
    always @(posedge clk_in)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data_in;
    end

    // Flags are registered so the ready seen upstream is a flop
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            count_q <= count_d;
            in_ready_out <= (count_d != DEPTH[AW:0]);
            out_valid_out <= (count_d != {(AW+1){1'b0}});
        end
    end
endmodule

module osdg_region (
    // Clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // Control
    input wire start_in,
    input wire [31:0] list_base_in,
    output reg overlay_on_out,
    output reg busy_out,
    // Descriptor and palette memory reads
    output reg mem_req_out,
    output reg [31:0] mem_addr_out,
    input wire mem_ack_in,
    input wire [31:0] mem_rdata_in,
    // Raster position
    input wire [10:0] vpos_in,
    input wire [11:0] hpos_in,
    input wire line_end_in,
    input wire field_bottom_in,
    // Region status toward the bitmap fetch and filter
    output reg region_active_out,
    output reg [31:0] fetch_addr_out,
    output reg flicker_en_out,
    output reg flutter_en_out,
    // Colour table read
    input wire [7:0] clut_rd_idx_in,
    output reg [31:0] clut_rd_data_out,
    // Filtered pixels in
    input wire pix_valid_in,
    input wire [9:0] pix_r_in,
    input wire [9:0] pix_g_in,
    input wire [9:0] pix_b_in,
    input wire [7:0] pix_alpha_in,
    output wire pix_ready_out,
    // Processed pixels out: mix factor, red, green, blue
    output wire out_valid_out,
    output wire [37:0] out_data_out,
    input wire out_ready_in
);
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_HDR = 4'h2;
    localparam [3:0] S_PAL = 4'h4;
    localparam [3:0] S_DISP = 4'h8;

    reg [3:0] state_q;
    reg [31:0] hdr_q [0:9];
    reg [31:0] clut_q [0:255];
    reg [3:0] word_idx_q;
    reg [8:0] pal_left_q;
    reg [7:0] pal_idx_q;
    reg [31:0] top_ptr_q;
    reg [31:0] bot_ptr_q;
    reg [11:0] line_cnt_q;
    reg [21:0] field_cnt_q;
    reg active_q;

    // Header fields
    wire stop_list = hdr_q[0][`OSDG_W0_STOP];
    wire new_palette = hdr_q[0][`OSDG_W0_NEWPAL];
    wire [1:0] filter_mode_sel = hdr_q[0][`OSDG_W0_FILT +: 2];
    wire [1:0] mix_mode_sel = hdr_q[0][`OSDG_W0_MIX +: 2];
    wire gain_enable = hdr_q[0][`OSDG_W0_GAIN_ENABLE];
    wire [5:0] gain_val = hdr_q[0][`OSDG_W0_GAIN +: 6];
    wire [9:0] offset_val = hdr_q[0][`OSDG_W0_OFFS +: 10];
    wire [7:0] palette_load_index = hdr_q[1][`OSDG_W1_LDIDX +: 8];
    wire [7:0] color_load_count = hdr_q[1][`OSDG_W1_LDCNT +: 8];
    wire [12:0] pitch_val = hdr_q[1][`OSDG_W1_PITCH +: 13];
    wire [21:0] field_pixel_total = hdr_q[2][`OSDG_W2_TOTAL +: 22];
    wire [11:0] line_pixel_count = hdr_q[3][`OSDG_W3_LINEPIX +: 12];
    wire [7:0] region_mix_weight = hdr_q[4][`OSDG_W4_WEIGHT +: 8];
    wire [10:0] y_bottom = hdr_q[4][`OSDG_W4_YBOT +: 11];
    wire [11:0] x_left = hdr_q[4][`OSDG_W4_XLEFT +: 12];
    wire [8:0] region_mix_gain = hdr_q[5][`OSDG_W5_MIXGAIN +: 9];
    wire [10:0] y_top = hdr_q[5][`OSDG_W5_YTOP +: 11];
    wire [11:0] x_right = hdr_q[5][`OSDG_W5_XRIGHT +: 12];

    // Clamp a blend factor to full overlay
    function [7:0] clamp_alpha;
        input [15:0] a;
        begin
            if (a > {8'h00, `OSDG_ALPHA_FULL})
                clamp_alpha = `OSDG_ALPHA_FULL;
            else
                clamp_alpha = a[7:0];
        end
    endfunction

    // Scale by gain/32 then add offset, saturating
    function [9:0] gain_offset;
        input [9:0] c;
        input [5:0] g;
        input [9:0] o;
        reg [15:0] prod;
        reg [11:0] sum;
        begin
            prod = {6'h00, c} * {10'h000, g};
            sum = {1'b0, prod[`OSDG_GAIN_SHIFT +: 11]} + {2'h0, o};
            if (sum > {2'h0, `OSDG_COLOR_MAX})
                gain_offset = `OSDG_COLOR_MAX;
            else
                gain_offset = sum[9:0];
        end
    endfunction

    // Window checks on the raster position
    wire in_rows = (vpos_in >= y_top) && (vpos_in < y_bottom);
    wire in_cols = (hpos_in >= x_left) && (hpos_in < x_right);
    wire line_room = (line_cnt_q < line_pixel_count);
    wire field_room = (field_cnt_q < field_pixel_total);
    wire region_now = (state_q == S_DISP) && in_rows && in_cols &&
                      line_room && field_room;
    wire field_done = (state_q == S_DISP) && !field_room;

    // Pixel stage feeding the buffer
    wire pix_take = pix_valid_in && pix_ready_out;
    wire apply_gain = active_q && gain_enable;
    wire [9:0] r_res = apply_gain ?
        gain_offset(pix_r_in, gain_val, offset_val) : pix_r_in;
    wire [9:0] g_res = apply_gain ?
        gain_offset(pix_g_in, gain_val, offset_val) : pix_g_in;
    wire [9:0] b_res = apply_gain ?
        gain_offset(pix_b_in, gain_val, offset_val) : pix_b_in;

    // Proportional mixing products
    wire [15:0] prop_mul = {8'h00, pix_alpha_in} *
                           {8'h00, region_mix_gain[7:0]};
    wire [15:0] prop_div = (region_mix_gain[7:0] == 8'h00) ? 16'hFFFF :
        ({1'b0, pix_alpha_in, 7'h00} / {8'h00, region_mix_gain[7:0]});

    // Blend factor never sees the colour gain
    reg [7:0] mix_factor;
    always @*
    begin
        mix_factor = `OSDG_ALPHA_FULL;
        if (active_q)
        begin
            case (mix_mode_sel)
                `OSDG_MIX_PIXEL:
                    mix_factor = clamp_alpha({8'h00, pix_alpha_in});
                `OSDG_MIX_GLOBAL:
                    mix_factor = clamp_alpha({8'h00, region_mix_weight});
                `OSDG_MIX_PROP:
                    mix_factor = region_mix_gain[8] ?
                        clamp_alpha(prop_mul) :
                        clamp_alpha(prop_div);
                default:
                    mix_factor = `OSDG_ALPHA_FULL;
            endcase
        end
        else
            mix_factor = 8'h00;
    end

    osdg_fifo #(
        .WIDTH(`OSDG_FIFO_WIDTH),
        .DEPTH(`OSDG_FIFO_DEPTH),
        .AW(`OSDG_FIFO_AW)
    ) u_fifo (
        .clk_in(clock_in),
        .rst_in(sys_rst_in),
        .in_valid_in(pix_valid_in),
        .in_data_in({mix_factor, r_res, g_res, b_res}),
        .in_ready_out(pix_ready_out),
        .out_valid_out(out_valid_out),
        .out_data_out(out_data_out),
        .out_ready_in(out_ready_in)
    );

    // Header words and palette entries land as memory answers
    always @(posedge clock_in)
    begin
        if (state_q == S_HDR && mem_ack_in)
            hdr_q[word_idx_q] <= mem_rdata_in;
        if (state_q == S_PAL && mem_ack_in)
            clut_q[pal_idx_q] <= mem_rdata_in;
        clut_rd_data_out <= clut_q[clut_rd_idx_in];
    end

    // Sequencer: descriptor, optional palette, then display
    always @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_q <= S_IDLE;
            word_idx_q <= 4'h0;
            pal_left_q <= 9'h000;
            pal_idx_q <= 8'h00;
            mem_req_out <= 1'b0;
            mem_addr_out <= 32'h0000_0000;
            overlay_on_out <= 1'b0;
            busy_out <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (start_in)
                    begin
                        state_q <= S_HDR;
                        word_idx_q <= 4'h0;
                        mem_req_out <= 1'b1;
                        mem_addr_out <= list_base_in;
                        busy_out <= 1'b1;
                        overlay_on_out <= 1'b1;
                    end
                end
                S_HDR:
                begin
                    if (mem_ack_in)
                    begin
                        mem_addr_out <= mem_addr_out + `OSDG_WORD_STEP;
                        word_idx_q <= word_idx_q + 4'h1;
                        if (word_idx_q == `OSDG_HDR_WORDS - 4'h1)
                        begin
                            // Word 0 already holds the palette bit
                            if (new_palette)
                            begin
                                state_q <= S_PAL;
                                mem_addr_out <= hdr_q[`OSDG_IDX_PALP];
                                pal_idx_q <= palette_load_index;
                                pal_left_q <= (color_load_count == 8'h00) ?
                                    9'h001 : {1'b0, color_load_count};
                            end
                            else
                            begin
                                state_q <= S_DISP;
                                mem_req_out <= 1'b0;
                            end
                        end
                    end
                end
                S_PAL:
                begin
                    if (mem_ack_in)
                    begin
                        mem_addr_out <= mem_addr_out + `OSDG_WORD_STEP;
                        pal_idx_q <= pal_idx_q + 8'h01;
                        pal_left_q <= pal_left_q - 9'h001;
                        if (pal_left_q == 9'h001)
                        begin
                            state_q <= S_DISP;
                            mem_req_out <= 1'b0;
                        end
                    end
                end
                S_DISP:
                begin
                    if (field_done)
                    begin
                        if (stop_list)
                        begin
                            state_q <= S_IDLE;
                            overlay_on_out <= 1'b0;
                            busy_out <= 1'b0;
                        end
                        else
                        begin
                            state_q <= S_HDR;
                            word_idx_q <= 4'h0;
                            mem_req_out <= 1'b1;
                            mem_addr_out <= hdr_q[`OSDG_IDX_NEXTP];
                        end
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // Field pointers, line and field pixel counts
    always @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            top_ptr_q <= 32'h0000_0000;
            bot_ptr_q <= 32'h0000_0000;
            line_cnt_q <= 12'h000;
            field_cnt_q <= 22'h000000;
        end
        else if (state_q != S_DISP)
        begin
            top_ptr_q <= hdr_q[`OSDG_IDX_TOPP];
            bot_ptr_q <= hdr_q[`OSDG_IDX_BOTP];
            line_cnt_q <= 12'h000;
            field_cnt_q <= 22'h000000;
        end
        else
        begin
            if (line_end_in)
            begin
                line_cnt_q <= 12'h000;
                if (in_rows && field_bottom_in)
                    bot_ptr_q <= bot_ptr_q + {19'h00000, pitch_val};
                else if (in_rows)
                    top_ptr_q <= top_ptr_q + {19'h00000, pitch_val};
            end
            else if (region_now && pix_take)
            begin
                line_cnt_q <= line_cnt_q + 12'h001;
                field_cnt_q <= field_cnt_q + 22'h000001;
            end
        end
    end

    // Registered status toward the pipeline
    always @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            active_q <= 1'b0;
            region_active_out <= 1'b0;
            fetch_addr_out <= 32'h0000_0000;
            flicker_en_out <= 1'b0;
            flutter_en_out <= 1'b0;
        end
        else
        begin
            active_q <= region_now;
            region_active_out <= region_now;
            fetch_addr_out <= field_bottom_in ? bot_ptr_q : top_ptr_q;
            // Reserved code 11 behaves as no filter
            flicker_en_out <= (state_q == S_DISP) &&
                (filter_mode_sel == `OSDG_FILT_FLICKER);
            flutter_en_out <= (state_q == S_DISP) &&
                (filter_mode_sel == `OSDG_FILT_FLUTTER);
        end
    end
endmodule

// ===== test/osdg_region_sva.sv
// Purpose: Port checks for the overlay region
// Assumes: One clock domain, reset asynchronous and active high
// Notes: Colour arithmetic is left to the bench comparisons
`timescale 1ns/1ps
module osdg_region_sva (
    // Clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // Control and memory side
    input wire start_in,
    input wire [31:0] list_base_in,
    input wire overlay_on_out,
    input wire busy_out,
    input wire mem_req_out,
    input wire [31:0] mem_addr_out,
    input wire mem_ack_in,
    // Region status
    input wire region_active_out,
    input wire flicker_en_out,
    input wire flutter_en_out,
    // Pixel stream
    input wire pix_valid_in,
    input wire [9:0] pix_r_in,
    input wire [9:0] pix_g_in,
    input wire [9:0] pix_b_in,
    input wire pix_ready_out,
    input wire out_valid_out,
    input wire [37:0] out_data_out,
    input wire out_ready_in
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    // Status outputs mirror each other
    property p_busy_mirror;
        busy_out == overlay_on_out;
    endproperty
    a_busy_mirror: assert property (p_busy_mirror)
        else $error("busy and overlay status differ");

    // Start reads the first header word at the base
    property p_start_fetch;
        start_in && !busy_out |=>
            mem_req_out && mem_addr_out == $past(list_base_in);
    endproperty
    a_start_fetch: assert property (p_start_fetch)
        else $error("first header read not at list base");

    // Pending read holds until acknowledged
    property p_req_hold;
        mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("read request dropped or moved before ack");

    // No memory traffic once the list has stopped
    property p_idle_quiet;
        !overlay_on_out |-> !mem_req_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("memory read while overlay off");

    // Filters exclusive, and only while overlay on
    property p_filter_excl;
        !(flicker_en_out && flutter_en_out) &&
            (overlay_on_out || !(flicker_en_out || flutter_en_out));
    endproperty
    a_filter_excl: assert property (p_filter_excl)
        else $error("filter enables inconsistent");

    // Region flag low once overlay stops
    property p_region_off;
        !overlay_on_out [*2] |-> !region_active_out;
    endproperty
    a_region_off: assert property (p_region_off)
        else $error("region active while overlay off");

    // An accepted pixel is visible on the next cycle
    property p_push_out;
        pix_valid_in && pix_ready_out |=> out_valid_out;
    endproperty
    a_push_out: assert property (p_push_out)
        else $error("pushed pixel not presented");

    // Stalled output holds its word
    property p_out_hold;
        out_valid_out && !out_ready_in |=>
            out_valid_out && $stable(out_data_out);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("output word changed under stall");

    // Refusal only when something is stored
    property p_full_ready;
        !pix_ready_out |-> out_valid_out;
    endproperty
    a_full_ready: assert property (p_full_ready)
        else $error("pixel refused with empty buffer");

    // Outside display, pixels pass untouched
    property p_bypass;
        pix_valid_in && pix_ready_out && !out_valid_out &&
            !overlay_on_out && !region_active_out |=>
            out_data_out == {8'h00, $past(pix_r_in), $past(pix_g_in),
            $past(pix_b_in)};
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("idle pixel altered");

    // Main scenarios reached
    c_start: cover property (start_in && !busy_out);
    c_full: cover property (!pix_ready_out);
    c_stop: cover property ($fell(overlay_on_out));
endmodule

// ===== test/osdg_mem_model.sv
// Purpose: Memory holding linked region headers and palettes
// Assumes: 64 words, addressed by bits 7:2
// Notes: Slow mode waits two extra cycles before each answer
`timescale 1ns/1ps
module osdg_mem_model (
    // Clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // Read port
    input wire req_in,
    input wire [31:0] addr_in,
    input wire slow_in,
    output reg ack_out,
    output reg [31:0] rdata_out
);
    reg [31:0] mem [0:63];
    reg [1:0] wait_q;
    int pal_reads;

    // One word per ack; data churns otherwise
    always @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ack_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            wait_q <= 2'h0;
            pal_reads <= 0;
        end
        else if (req_in && !ack_out && wait_q == (slow_in ? 2'h2 : 2'h0))
        begin
            ack_out <= 1'b1;
            rdata_out <= mem[addr_in[7:2]];
            wait_q <= 2'h0;
            // Palette area from C0h
            if (addr_in >= 32'h0000_00C0)
                pal_reads <= pal_reads + 1;
        end
        else
        begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
            wait_q <= (req_in && !ack_out) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the overlay region block
// Assumes: Four linked regions, one per mix mode, last one stops
// Notes: Pixels are pushed and popped one at a time
`timescale 1ns/1ps
module tb_top;
    reg clock_in = 0;
    reg sys_rst_in = 1;
    reg start_in = 0;
    reg [31:0] list_base_in = 32'h0;
    reg [10:0] vpos_in = 11'h0;
    reg [11:0] hpos_in = 12'h0;
    reg line_end_in = 0;
    reg field_bottom_in = 0;
    reg [7:0] clut_rd_idx_in = 8'h0;
    reg pix_valid_in = 0;
    reg [9:0] pix_r_in = 10'h0;
    reg [9:0] pix_g_in = 10'h0;
    reg [9:0] pix_b_in = 10'h0;
    reg [7:0] pix_alpha_in = 8'h0;
    reg out_ready_in = 0;
    reg slow = 0;
    wire overlay_on_out, busy_out, mem_req_out, mem_ack_in;
    wire region_active_out, flicker_en_out, flutter_en_out;
    wire pix_ready_out, out_valid_out;
    wire [31:0] mem_addr_out, mem_rdata_in, fetch_addr_out, clut_rd_data_out;
    wire [37:0] out_data_out;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int n, k, i;
    reg [31:0] hdr_at;

    always #25 clock_in = ~clock_in;

    osdg_region dut (.*);

    // Header fetch start address, before the first ack moves it
    always @(posedge mem_req_out)
        @(negedge clock_in) hdr_at = mem_addr_out;

    osdg_mem_model u_mem (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .req_in(mem_req_out), .addr_in(mem_addr_out), .slow_in(slow),
        .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

    task chk(input string nm, input [37:0] seen, input [37:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                bad_count++;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task give_verdict;
        begin
            if (bad_count == 0 && checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // Hold pixel until taken
    task push(input [9:0] r, input [9:0] g, input [9:0] b, input [7:0] a);
        begin
            @(posedge clock_in);
            pix_valid_in <= 1;
            pix_r_in <= r;
            pix_g_in <= g;
            pix_b_in <= b;
            pix_alpha_in <= a;
            @(posedge clock_in);
            while (!pix_ready_out)
                @(posedge clock_in);
            pix_valid_in <= 0;
        end
    endtask

    task pop(input [37:0] e);
        begin
            n = 0;
            @(negedge clock_in);
            while (out_valid_out !== 1'b1 && n < 20)
            begin
                @(negedge clock_in);
                n++;
            end
            chk("out_data", out_data_out, e);
            @(posedge clock_in);
            out_ready_in <= 1;
            @(posedge clock_in);
            out_ready_in <= 0;
        end
    endtask

    task wait_req(input v);
        begin
            n = 0;
            @(negedge clock_in);
            while (mem_req_out !== v && n < 300)
            begin
                @(negedge clock_in);
                n++;
            end
        end
    endtask

    // Expected colour: gain 3Fh over 32, offset 10h, saturated
    function [9:0] gx(input [9:0] c, input en);
        reg [16:0] t;
        begin
            t = ((c * 17'h3F) >> 5) + 17'h10;
            gx = !en ? c : (t > 17'h3FF ? 10'h3FF : t[9:0]);
        end
    endfunction

    // Expected mix: alpha 30h, weight 40h, gain x2
    function [7:0] mx(input [1:0] m);
        mx = (m == 2'h0) ? 8'h30 : (m == 2'h1) ? 8'h40 :
            (m == 2'h2) ? 8'h60 : 8'h80;
    endfunction

    // Region k: mix mode k, gain on odd k, stop on the last
    task header(input int r);
        begin
            u_mem.mem[r*10] = {r == 3, r == 0, (r == 3) ? 2'h0 : r[1:0],
                r[1:0], r[0], 6'h3F, 9'h000, 10'h010};
            u_mem.mem[r*10+1] = {8'h05, 8'h00, 3'h0, 13'h0100};
            u_mem.mem[r*10+2] = 32'h0000_0020;
            u_mem.mem[r*10+3] = 32'h0000_0040;
            u_mem.mem[r*10+4] = {8'h40, 1'b0, 11'h00A, 12'h064};
            u_mem.mem[r*10+5] = {9'h102, 11'h004, 12'h0C8};
            u_mem.mem[r*10+6] = 32'h0000_1000 + r * 32'h100;
            u_mem.mem[r*10+7] = 32'h0000_2000 + r * 32'h100;
            u_mem.mem[r*10+8] = 32'h0000_00C0;
            u_mem.mem[r*10+9] = (r + 1) * 40;
        end
    endtask

    // Cut a hang short
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            give_verdict;
        end
    end

    initial
    begin
        for (k = 0; k < 4; k++)
            header(k);
        u_mem.mem[48] = 32'hA1B2_C3D4;
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 0;
        @(negedge clock_in);
        chk("pix_ready", pix_ready_out, 1);
        chk("overlay_on", overlay_on_out, 0);
        // Fill until refused, drain in order
        for (i = 0; i < 8; i++)
            push(i, i + 1, i + 2, 8'h10);
        @(negedge clock_in);
        chk("pix_ready_full", pix_ready_out, 0);
        for (i = 0; i < 8; i++)
            pop({8'h00, i[9:0], i[9:0] + 10'h1, i[9:0] + 10'h2});
        @(posedge clock_in);
        start_in <= 1;
        @(posedge clock_in);
        start_in <= 0;
        for (k = 0; k < 4; k++)
        begin
            slow <= k[0];
            wait_req(1);
            @(negedge clock_in);
            chk("hdr_addr", hdr_at, k * 40);
            wait_req(0);
            if (k == 0)
            begin
                @(posedge clock_in);
                clut_rd_idx_in <= 8'h05;
                repeat (2) @(posedge clock_in);
                @(negedge clock_in);
                chk("clut", clut_rd_data_out, 32'hA1B2_C3D4);
            end
            @(posedge clock_in);
            vpos_in <= 11'h005;
            hpos_in <= 12'h096;
            repeat (2) @(posedge clock_in);
            @(negedge clock_in);
            chk("fetch", fetch_addr_out, 32'h2000 + k * 32'h100);
            chk("active", region_active_out, 1);
            chk("flicker", flicker_en_out, k == 1);
            chk("flutter", flutter_en_out, k == 2);
            push(10'h3FF, 10'd300, 10'h000, 8'h30);
            pop({mx(k), gx(10'h3FF, k[0]), gx(10'd300, k[0]),
                gx(10'h000, k[0])});
            @(posedge clock_in);
            line_end_in <= 1;
            @(posedge clock_in);
            line_end_in <= 0;
            repeat (2) @(negedge clock_in);
            chk("pitch", fetch_addr_out, 32'h2100 + k * 32'h100);
            // Run the region out
            @(posedge clock_in);
            out_ready_in <= 1;
            i = 0;
            while (mem_req_out === 1'b0 && overlay_on_out === 1'b1 && i < 80)
            begin
                push(10'h001, 10'h002, 10'h003, 8'h30);
                i++;
            end
            repeat (3) @(posedge clock_in);
            out_ready_in <= 0;
            hpos_in <= 12'h000;
        end
        wait_req(0);
        repeat (4) @(negedge clock_in);
        chk("overlay_off", overlay_on_out, 0);
        chk("pal_reads", u_mem.pal_reads, 1);
        give_verdict;
    end
endmodule

bind osdg_region osdg_region_sva u_sva (.*);
